//--- logic/interrupt_latch_priority_control.sv
// Summary of operation
// - Twenty-one sources besides reset; four internal ones are non-maskable.
// - Nesting allowed; a new request may be accepted during service.
// - Request sets its latch, held until acceptance, reset or clear.
// - Maskable request forwarded only with master and own enable set.
// - Simultaneous requests chosen by fixed order, smaller number wins.
// - Non-maskable sources rank above all others in fixed order: software/undefined, then trap, then watchdog.
// - Vectors FFFE reset, FFFC software/undefined, FFFA trap, FFF8 watchdog.
// - Latches 4-15 vectors FFF6 down, 16-23 vectors FFBE down.
// - External 0 needs master enable, own enable and pin enable.
// - Every source has a latch except software and undefined opcode.
// - Latch clears at once when its interrupt is accepted.
// - All latches are zero during reset.
// - Latches sit at SFR bytes 2E, 3C and 3D.
// - Writing zero clears a latch bit; writing one leaves it.
// - No write can set a latch; only hardware requests do.
// - Latch reads return the current pending state.
// - A disabled latch stays pending and raises no request.
// - Acceptance saves then clears master enable; return restores it.
// - Acceptance sequence lasts eight machine cycles.
// - Pushes status plus enable, PC high, PC low; stack drops three.
// - Master enable is bit 0 of low enable byte; enables reset zero.
`timescale 1ns/1ps
`include "intc_defs.svh"
module interrupt_latch_priority_control #(
  parameter int MCYC_CLKS = `MCYC_CLKS // Clocks per machine cycle
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire intc_pkg::irq_sources_t irq_in, // One-cycle request pulses
  input wire logic software_irq, // Software interrupt, held by CPU
  input wire logic illegal_opcode_irq, // Undefined opcode, held by CPU
  input wire logic ext0_pin_enable, // Pin function enable of ext 0
  input wire intc_pkg::sfr_bus_t sfr, // SFR byte access
  output logic [7:0] sfr_rdata, // Read data, one cycle after rd
  output logic irq_request, // Request to the CPU
  output logic [15:0] irq_vector, // Vector of the current winner
  input wire logic cpu_accept, // CPU takes the request
  input wire logic [7:0] cpu_psw, // Status word to stack
  input wire logic [15:0] cpu_pc, // Return address
  input wire logic [15:0] cpu_sp, // Stack pointer
  input wire logic ret_load, // Return instruction pops status
  input wire logic ret_imf, // Master enable from popped status
  output intc_pkg::stack_push_t push, // Stack byte write
  output logic sp_load, // Load new stack pointer
  output logic [15:0] sp_value, // Stack pointer after pushes
  output logic pc_load, // Load vector into program counter
  output logic [15:0] pc_value, // Vector to load
  output logic seq_busy // Acceptance sequence running
);
  localparam int CW = $clog2(MCYC_CLKS + 1);
  logic [23:0] latch;
  logic [23:4] enable;
  logic global_irq_enable;
  intc_pkg::seq_state_t state;
  logic [2:0] step;
  logic [CW-1:0] div;
  logic [4:0] taken;
  logic [7:0] psw_saved;
  logic [15:0] pc_saved, sp_saved;

  // Machine cycle enable from a divider
  wire mcyc_en = (div == CW'(MCYC_CLKS - 1));
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) div <= '0;
    else if (mcyc_en) div <= '0;
    else div <= div + CW'(1);
  end

  // Register decode
  wire wr_a = sfr.wr && sfr.addr == `ADDR_LATCH_A;
  wire wr_b = sfr.wr && sfr.addr == `ADDR_LATCH_B;
  wire wr_c = sfr.wr && sfr.addr == `ADDR_LATCH_C;
  wire wr_ea = sfr.wr && sfr.addr == `ADDR_EN_A;
  wire wr_el = sfr.wr && sfr.addr == `ADDR_EN_LOW;
  wire wr_eh = sfr.wr && sfr.addr == `ADDR_EN_HIGH;

  // Zero bits of a write pick latches to clear; ones do nothing
  wire [23:0] wr_clear = {wr_a ? ~sfr.wdata : 8'h00,
                          wr_c ? ~sfr.wdata : 8'h00,
                          wr_b ? ~sfr.wdata : 8'h00};

  // Eligibility per source
  wire [23:0] eligible;
  assign eligible[0] = 1'b0;
  assign eligible[1] = software_irq | illegal_opcode_irq;
  assign eligible[2] = latch[2];
  assign eligible[3] = latch[3];
  assign eligible[4] = latch[4] & enable[4] & global_irq_enable & ext0_pin_enable;
  assign eligible[23:5] = latch[23:5] & enable[23:5]
                          & {19{global_irq_enable}};

  // Lowest index wins; the non-maskable group sits ahead of all others
  function automatic logic [4:0] pick(input logic [23:0] e);
    logic [4:0] w;
    w = '0;
    for (int i = `SRC_LAST; i >= 1; i--) begin
      if (e[i]) w = 5'(i);
    end
    return w;
  endfunction : pick

  // Vector of a source index
  function automatic logic [15:0] vec_of(input logic [4:0] s);
    logic [15:0] v;
    v = `VEC_SOFT;
    if (s == `SRC_NONE) v = `VEC_RESET; // Nothing pending
    else if (s == `SRC_TRAP) v = `VEC_TRAP;
    else if (s == `SRC_WDOG) v = `VEC_WDOG;
    else if (s >= `SRC_BANK1)
      v = `VEC_BANK1_TOP - {10'h000, s - `SRC_BANK1, 1'b0};
    else if (s >= `SRC_EXT0)
      v = `VEC_BANK0_TOP - {10'h000, s - `SRC_EXT0, 1'b0};
    return v;
  endfunction : vec_of

  wire [4:0] winner = pick(eligible);
  wire idle = (state == intc_pkg::ST_IDLE);
  assign irq_request = idle && winner != 5'h00;
  wire accept = irq_request && cpu_accept;
  wire [23:0] acc_clear = accept ? 24'h000001 << winner : 24'h000000;

  // Latches: hardware set beats any clear in the same cycle
  // Bits 1:0 never latch; those sources hold their own level
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) latch <= '0;
    else latch <= (latch & ~wr_clear & ~acc_clear)
                  | (irq_in & ~`NO_LATCH_BITS);
  end

  // Enable flags and master enable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable <= '0;
      global_irq_enable <= 1'b0;
    end else begin
      if (wr_el) enable[7:4] <= sfr.wdata[7:4];
      if (wr_eh) enable[15:8] <= sfr.wdata;
      if (wr_ea) enable[23:16] <= sfr.wdata;
      if (accept) global_irq_enable <= 1'b0;
      else if (ret_load) global_irq_enable <= ret_imf;
      else if (wr_el) global_irq_enable <= sfr.wdata[`IMF_BIT];
    end
  end

  // Registered read data; unmapped addresses read zero
  wire [7:0] rd_mux =
    sfr.addr == `ADDR_LATCH_A ? latch[23:16] :
    sfr.addr == `ADDR_LATCH_B ? {latch[7:2], 2'b00} :
    sfr.addr == `ADDR_LATCH_C ? latch[15:8] :
    sfr.addr == `ADDR_EN_A ? enable[23:16] :
    sfr.addr == `ADDR_EN_LOW ? {enable[7:4], 3'b000, global_irq_enable} :
    sfr.addr == `ADDR_EN_HIGH ? enable[15:8] : `REG_RESET;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) sfr_rdata <= `REG_RESET;
    else if (sfr.rd) sfr_rdata <= rd_mux;
  end

  // Vector follows the winner, registered for a clean data output
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) irq_vector <= `VEC_RESET;
    else irq_vector <= vec_of(pick(eligible));
  end

  // Acceptance sequencer; stacked status carries the pre-accept enable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= intc_pkg::ST_IDLE;
      step <= '0;
      taken <= '0;
      psw_saved <= '0;
      pc_saved <= '0;
      sp_saved <= '0;
    end else begin
      unique case (state)
        intc_pkg::ST_IDLE: begin
          if (accept) begin
            state <= intc_pkg::ST_SEQ;
            step <= '0;
            taken <= winner;
            psw_saved <= {cpu_psw[7:1], global_irq_enable};
            pc_saved <= cpu_pc;
            sp_saved <= cpu_sp;
          end
        end
        intc_pkg::ST_SEQ: begin
          if (mcyc_en) begin
            step <= step + 3'h1;
            if (step == `SEQ_LAST) state <= intc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end
  assign seq_busy = !idle;

  // Push bytes in the first three machine cycles, then load the vector
  wire seq_tick = !idle && mcyc_en;
  wire [7:0] push_byte = step == 3'h0 ? psw_saved :
                         step == 3'h1 ? pc_saved[15:8] : pc_saved[7:0];
  wire [15:0] push_addr = sp_saved - {13'h0000, step};
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      push <= '0;
      sp_load <= 1'b0;
      sp_value <= '0;
      pc_load <= 1'b0;
      pc_value <= '0;
    end else begin
      push.wr <= seq_tick && step <= `STEP_PCL;
      push.addr <= push_addr;
      push.data <= push_byte;
      sp_load <= seq_tick && step == `STEP_PCL;
      sp_value <= sp_saved - `PUSH_BYTES;
      pc_load <= seq_tick && step == `STEP_PC_LOAD;
      pc_value <= vec_of(taken);
    end
  end

  // Helper: machine cycles counted over one sequence
  logic [3:0] mc_count;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) mc_count <= '0;
    else if (accept) mc_count <= '0;
    else if (seq_tick) mc_count <= mc_count + 4'h1;
  end

  sequence s_wr_clears(int b);
    wr_b && !sfr.wdata[b] && !irq_in[b] && !acc_clear[b];
  endsequence
  sequence s_accepted;
    accept ##1 !idle;
  endsequence

  // Latch behaviour against requests, writes and acceptance
  a_latch_set: assert property (@(posedge clk_sys)
    disable iff (!reset_n) irq_in[9] |=> latch[9])
    else $error("request lost");
  a_write_zero_clears: assert property (@(posedge clk_sys)
    disable iff (!reset_n) s_wr_clears(5) |=> !latch[5])
    else $error("zero write did not clear");
  a_write_no_set: assert property (@(posedge clk_sys)
    disable iff (!reset_n) !latch[6] && !irq_in[6] |=> !latch[6])
    else $error("latch set without request");
  a_set_beats_clear: assert property (@(posedge clk_sys)
    disable iff (!reset_n) wr_b && !sfr.wdata[6] && irq_in[6] |=> latch[6])
    else $error("clear beat a request");
  a_accept_clears: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    accept && winner >= `SRC_TRAP && !irq_in[winner] |=> !latch[taken])
    else $error("accepted latch still set");
  a_imf_saved: assert property (@(posedge clk_sys)
    disable iff (!reset_n) s_accepted |-> !global_irq_enable && psw_saved[0] == $past(global_irq_enable))
    else $error("master enable not saved and cleared");
  a_mask_gate: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    irq_request && winner > `SRC_WDOG |-> global_irq_enable && enable[winner])
    else $error("masked request forwarded");
  a_ext0_gate: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    irq_request && winner == `SRC_EXT0 |-> ext0_pin_enable)
    else $error("ext 0 without pin enable");
  a_priority_order: assert property (@(posedge clk_sys)
    disable iff (!reset_n) latch[8] && enable[8] && global_irq_enable |-> winner <= 5'h08)
    else $error("lower priority won");
  a_seq_length: assert property (@(posedge clk_sys)
    disable iff (!reset_n) $fell(seq_busy) |-> mc_count == `SEQ_MCYC)
    else $error("sequence not eight machine cycles");
  a_stack_drop: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    sp_load |-> push.wr && sp_value == sp_saved - `PUSH_BYTES
                && push.addr == sp_saved - `PUSH_BYTES + 16'h0001)
    else $error("stack not lowered by three");
  // Non-maskable latches must reach the CPU with every enable off
  a_nmi_unmasked: assert property (@(posedge clk_sys)
    disable iff (!reset_n) idle && (latch[2] || latch[3]) |-> irq_request)
    else $error("non-maskable request blocked");
  // Vector register trails the winner by one clock
  a_soft_vector: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    irq_request && winner == `SRC_SOFT |=> irq_vector == `VEC_SOFT)
    else $error("software vector wrong");
  a_trap_vector: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    irq_request && winner == `SRC_TRAP |=> irq_vector == `VEC_TRAP)
    else $error("trap vector wrong");
  a_ext0_vector: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    irq_request && winner == `SRC_EXT0 |=> irq_vector == `VEC_BANK0_TOP)
    else $error("ext 0 vector wrong");
  a_bank1_vector: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    irq_request && winner == `SRC_BANK1 |=> irq_vector == `VEC_BANK1_TOP)
    else $error("upper bank vector wrong");
  // Read data shows the latch state of the cycle of the strobe
  a_latch_readback: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    sfr.rd && sfr.addr == `ADDR_LATCH_C |=> sfr_rdata == $past(latch[15:8]))
    else $error("latch read wrong");
endmodule : interrupt_latch_priority_control

//--- logic/intc_defs.svh
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH
// Special-function register byte addresses
`define ADDR_LATCH_A 8'h2e
`define ADDR_LATCH_B 8'h3c
`define ADDR_LATCH_C 8'h3d
`define ADDR_EN_A 8'h2c
`define ADDR_EN_LOW 8'h3a
`define ADDR_EN_HIGH 8'h3b
`define IMF_BIT 0
`define REG_RESET 8'h00
// Source indices; index 1 stands for the two latch-less sources
`define SRC_NONE 5'h00
`define SRC_SOFT 5'h01
`define SRC_TRAP 5'h02
`define SRC_WDOG 5'h03
`define SRC_EXT0 5'h04
`define SRC_BANK1 5'h10
`define SRC_LAST 23
`define NO_LATCH_BITS 24'h000003
// Vector addresses
`define VEC_RESET 16'hfffe
`define VEC_SOFT 16'hfffc
`define VEC_TRAP 16'hfffa
`define VEC_WDOG 16'hfff8
`define VEC_BANK0_TOP 16'hfff6
`define VEC_BANK1_TOP 16'hffbe
// Acceptance sequence, in machine cycles
`define SEQ_MCYC 4'h8
`define SEQ_LAST 3'h7
`define PUSH_BYTES 16'h0003
`define STEP_PCL 3'h2
`define STEP_PC_LOAD 3'h3
`define MCYC_CLKS 4
`endif

//--- logic/intc_pkg.sv
package intc_pkg;
  // Request lines, packed so that bit n is latch n
  typedef struct packed {
    logic reserved_23, reserved_22, ext_irq_five, reserved_20;
    logic timer_six_irq, timer_five_irq, timer_four_irq, timer_three_irq;
    logic sync_serial_irq, ext_irq_four, ext_irq_three;
    logic serial1_transmit_irq, serial1_receive_irq;
    logic serial0_transmit_irq, serial0_receive_irq, timer_one_irq;
    logic ext_irq_two, time_base_irq, ext_irq_one, ext_irq_zero;
    logic wdog_irq, address_trap_irq;
    logic [1:0] no_latch;
  } irq_sources_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_bus_t;
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } stack_push_t;
  typedef enum logic {ST_IDLE, ST_SEQ} seq_state_t;
endpackage : intc_pkg

//--- test/cpu_core_model.sv
`timescale 1ns/1ps
// CPU side: takes requests, holds trap levels, keeps the stack
module cpu_core_model (
  input wire logic clk_sys, // clock
  input wire logic reset_n, // reset, active low
  input wire logic take_en, // accepting allowed
  input wire logic [1:0] trap_req, // raise {undefined, software}
  input wire logic irq_request, // request in
  input wire intc_pkg::stack_push_t push, // stack write
  input wire logic sp_load, // pointer strobe
  input wire logic [15:0] sp_value, // new pointer
  input wire logic pc_load, // vector strobe
  input wire logic [15:0] pc_value, // vector
  output logic cpu_accept, // accept strobe
  output logic software_irq, // software trap level
  output logic illegal_opcode_irq, // undefined opcode level
  output logic [7:0] cpu_psw, // status word
  output logic [15:0] cpu_pc, // return address
  output logic [15:0] cpu_sp // stack pointer
);
  logic [7:0] stack_mem [0:255];
  logic [15:0] sp_seen;
  logic [15:0] pc_seen;
  logic [1:0] traps;
  // Fixed context so the stacked bytes are known
  assign cpu_psw = 8'ha4;
  assign cpu_pc = 16'h1234;
  assign cpu_sp = 16'h00f0;
  assign {illegal_opcode_irq, software_irq} = traps;
  // One accept pulse per request, never two in a row
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cpu_accept <= 1'b0;
      traps <= 2'b00;
    end else begin
      cpu_accept <= take_en & irq_request & ~cpu_accept;
      // No latch for these; the level is dropped when any request is taken
      if (cpu_accept & irq_request)
        traps <= 2'b00;
      else
        traps <= traps | trap_req;
    end
  end
  // Stack bytes and last pointer and vector, for inspection
  always_ff @(posedge clk_sys) begin
    if (push.wr) stack_mem[push.addr[7:0]] <= push.data;
    if (sp_load) sp_seen <= sp_value;
    if (pc_load) pc_seen <= pc_value;
  end
endmodule : cpu_core_model

//--- test/interrupt_latch_priority_control_tb_top.sv
`timescale 1ns/1ps
module interrupt_latch_priority_control_tb_top;
  logic clk_sys, reset_n, ext0_pin_enable, ret_load, ret_imf, take_en;
  logic cpu_accept, software_irq, illegal_opcode_irq;
  logic irq_request, sp_load, pc_load, seq_busy;
  logic [1:0] trap_req;
  logic [7:0] sfr_rdata, cpu_psw;
  logic [15:0] irq_vector, sp_value, pc_value, cpu_pc, cpu_sp;
  intc_pkg::irq_sources_t irq_in;
  intc_pkg::sfr_bus_t sfr;
  intc_pkg::stack_push_t push;
  int n_errors = 0;
  int n_compared = 0;
  int n;
  // One clock per machine cycle keeps the sequence short
  interrupt_latch_priority_control #(.MCYC_CLKS(1))
      interrupt_latch_priority_control_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .irq_in(irq_in),
    .software_irq(software_irq), .illegal_opcode_irq(illegal_opcode_irq),
    .ext0_pin_enable(ext0_pin_enable), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .irq_request(irq_request), .irq_vector(irq_vector),
    .cpu_accept(cpu_accept), .cpu_psw(cpu_psw), .cpu_pc(cpu_pc),
    .cpu_sp(cpu_sp), .ret_load(ret_load), .ret_imf(ret_imf), .push(push),
    .sp_load(sp_load), .sp_value(sp_value), .pc_load(pc_load),
    .pc_value(pc_value), .seq_busy(seq_busy));
  cpu_core_model cpu_core_model_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .take_en(take_en),
    .trap_req(trap_req), .irq_request(irq_request), .push(push),
    .sp_load(sp_load), .sp_value(sp_value), .pc_load(pc_load),
    .pc_value(pc_value), .cpu_accept(cpu_accept),
    .software_irq(software_irq), .illegal_opcode_irq(illegal_opcode_irq),
    .cpu_psw(cpu_psw), .cpu_pc(cpu_pc), .cpu_sp(cpu_sp));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string s, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Register strobes last one cycle; reads answer a cycle later
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    sfr <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    sfr <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_sys);
    sfr <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    sfr <= '0;
    #1 chk("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata});
  endtask : rd
  task automatic raise(input logic [23:0] b, input logic [1:0] t);
    @(posedge clk_sys);
    irq_in <= b;
    trap_req <= t;
    @(posedge clk_sys);
    irq_in <= '0;
    trap_req <= 2'b00;
  endtask : raise
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : idle
  function automatic logic [15:0] vec_of(input int i);
    if (i < 16) return 16'hfff6 - 16'(2 * (i - 4));
    return 16'hffbe - 16'(2 * (i - 16));
  endfunction : vec_of
  // Waits out one acceptance; each wait gives up after 200 cycles
  task automatic run_seq(input logic [15:0] v);
    int i;
    int c;
    for (i = 0; i < 200 && seq_busy !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    for (c = 0; c < 200 && seq_busy === 1'b1; c++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("busy_8_to_10", 16'h0001, {15'h0000, c >= 8 && c <= 10});
    chk("pc_value", v, cpu_core_model_i.pc_seen);
  endtask : run_seq
  task automatic t_reset;
    chk("irq_vector", 16'hfffe, irq_vector);
    rd(8'h2e, 8'h00);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    rd(8'h3a, 8'h00);
    rd(8'h10, 8'h00);
  endtask : t_reset
  task automatic t_latch;
    raise(24'h010220, 2'b00);
    rd(8'h3c, 8'h20);
    rd(8'h3d, 8'h02);
    rd(8'h2e, 8'h01);
    wr(8'h3c, 8'hff);
    wr(8'h2e, 8'hff);
    rd(8'h3c, 8'h20);
    rd(8'h2e, 8'h01);
    wr(8'h3c, 8'hdf);
    wr(8'h3d, 8'h00);
    wr(8'h2e, 8'h00);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
  endtask : t_latch
  // Request lands on the very edge of a clearing write
  task automatic t_race;
    @(posedge clk_sys);
    sfr <= '{addr: 8'h3c, wdata: 8'h0c, wr: 1'b1, rd: 1'b0};
    irq_in <= 24'h000040;
    @(posedge clk_sys);
    sfr <= '0;
    irq_in <= '0;
    rd(8'h3c, 8'h40);
    wr(8'h3c, 8'h0c);
  endtask : t_race
  task automatic t_mask;
    wr(8'h3a, 8'h20);
    raise(24'h000020, 2'b00);
    idle(3);
    chk("irq_request", 16'h0000, {15'h0000, irq_request});
    rd(8'h3c, 8'h20);
    wr(8'h3a, 8'h21);
    idle(3);
    chk("irq_request", 16'h0001, {15'h0000, irq_request});
    wr(8'h3a, 8'h01);
    idle(3);
    chk("irq_request", 16'h0000, {15'h0000, irq_request});
    wr(8'h3a, 8'h10);
    wr(8'h3c, 8'h0c);
    raise(24'h000010, 2'b00);
    wr(8'h3a, 8'h11);
    idle(3);
    chk("irq_request", 16'h0000, {15'h0000, irq_request});
    @(posedge clk_sys);
    ext0_pin_enable <= 1'b1;
    idle(3);
    chk("irq_request", 16'h0001, {15'h0000, irq_request});
    chk("irq_vector", 16'hfff6, irq_vector);
    wr(8'h3a, 8'h00);
    wr(8'h3c, 8'h0c);
  endtask : t_mask
  // Each new lower number must take over the vector
  task automatic t_prio;
    wr(8'h2c, 8'hff);
    wr(8'h3b, 8'hff);
    wr(8'h3a, 8'hf0);
    wr(8'h3a, 8'hf1);
    rd(8'h2c, 8'hff);
    rd(8'h3b, 8'hff);
    for (n = 23; n >= 4; n--) begin
      raise(24'h000001 << n, 2'b00);
      idle(2);
      chk("irq_vector", vec_of(n), irq_vector);
    end
    wr(8'h3a, 8'hf0);
    wr(8'h3c, 8'h0c);
    wr(8'h3d, 8'h00);
    wr(8'h2e, 8'h00);
    idle(2);
    chk("irq_request", 16'h0000, {15'h0000, irq_request});
  endtask : t_prio
  // Master enable is off; trap and watchdog act as interrupts
  task automatic t_nmi;
    @(posedge clk_sys);
    take_en <= 1'b1;
    raise(24'h000000, 2'b01);
    run_seq(16'hfffc);
    raise(24'h000000, 2'b10);
    run_seq(16'hfffc);
    raise(24'h00000c, 2'b00);
    run_seq(16'hfffa);
    run_seq(16'hfff8);
    rd(8'h3c, 8'h00);
  endtask : t_nmi
  task automatic t_accept;
    raise(24'h000020, 2'b00);
    wr(8'h3a, 8'hf1);
    run_seq(16'hfff4);
    chk("stack_psw", 16'h00a5, cpu_core_model_i.stack_mem[8'hf0]);
    chk("stack_pch", 16'h0012, cpu_core_model_i.stack_mem[8'hef]);
    chk("stack_pcl", 16'h0034, cpu_core_model_i.stack_mem[8'hee]);
    chk("sp_value", 16'h00ed, cpu_core_model_i.sp_seen);
    rd(8'h3c, 8'h00);
    rd(8'h3a, 8'hf0);
    raise(24'h000008, 2'b00);
    run_seq(16'hfff8);
    chk("stack_psw", 16'h00a4, cpu_core_model_i.stack_mem[8'hf0]);
    raise(24'h000200, 2'b00);
    idle(4);
    chk("irq_request", 16'h0000, {15'h0000, irq_request});
    @(posedge clk_sys);
    ret_load <= 1'b1;
    ret_imf <= 1'b1;
    @(posedge clk_sys);
    ret_load <= 1'b0;
    run_seq(16'hffec);
    @(posedge clk_sys);
    take_en <= 1'b0;
  endtask : t_accept
  // Reset in mid-run must drop latches, enables and master enable
  task automatic t_reset_mid;
    raise(24'h000a20, 2'b00);
    wr(8'h3a, 8'hf1);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    idle(2);
    chk("irq_vector", 16'hfffe, irq_vector);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    rd(8'h3a, 8'h00);
    rd(8'h2c, 8'h00);
  endtask : t_reset_mid
  task automatic report_and_stop;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    report_and_stop;
  end
  initial begin
    reset_n = 1'b0;
    ext0_pin_enable = 1'b0;
    ret_load = 1'b0;
    ret_imf = 1'b0;
    take_en = 1'b0;
    trap_req = 2'b00;
    irq_in = '0;
    sfr = '0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    idle(2);
    t_reset;
    t_latch;
    t_race;
    t_mask;
    t_prio;
    t_nmi;
    t_accept;
    t_reset_mid;
    report_and_stop;
  end
endmodule : interrupt_latch_priority_control_tb_top
